// *** include/psl_pkg.sv ***
// Purpose: Shared constants for the remappable pin select block
// Assumes: 16-bit register port, word index addressing
// Notes: Pin masks cover codes 0..63, bit n set when pin n exists
package psl_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int SEL_W = 6;
  localparam int NUM_CODES = 64;
  localparam int IO_PINS = 32;
  localparam int ALL_PINS = 44;
  // Register map, word index on the register port
  localparam logic [7:0] OSC_IDX = 8'h00;
  localparam logic [7:0] STAT_IDX = 8'h01;
  localparam logic [7:0] IN_BASE = 8'h10;
  localparam logic [7:0] OUT_BASE = 8'h40;
  // Field positions
  localparam int LOCK_BIT = 6;
  localparam int FUSE_BIT = 4;
  localparam int HI_LSB = 8;
  // Unlock keys in the low byte of the oscillator control register
  localparam logic [7:0] KEY_FIRST = 8'h46;
  localparam logic [7:0] KEY_SECOND = 8'h57;
  // Reset values and special codes
  localparam logic [SEL_W-1:0] IN_RST = 6'h3f;
  localparam logic [SEL_W-1:0] OUT_RST = 6'h00;
  localparam logic [SEL_W-1:0] NULL_FN = 6'h00;
  localparam logic [SEL_W-1:0] MAX_VALID = 6'h2b;
  // Implemented pins per variant
  localparam logic [63:0] IMPL_LARGE = 64'h0000_0fff_ffff_ffff;
  localparam logic [63:0] IMPL_SMALL = 64'h0000_0020_3fff_7fdf;
  typedef enum logic [1:0] {
    PSL_IDLE = 2'b00,
    PSL_KEY1 = 2'b01,
    PSL_KEY2 = 2'b10
  } psl_key_t;
endpackage : psl_pkg

// *** src/psl_in_mux.sv ***
// Purpose: One peripheral input selector with a registered output
// Assumes: Pin inputs synchronous to clk
// Notes: Invalid or missing pins give a constant low
`timescale 1ns/1ns
module psl_in_mux (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [psl_pkg::SEL_W-1:0] sel,
  input wire logic [psl_pkg::ALL_PINS-1:0] pin_in,
  input wire logic [psl_pkg::ALL_PINS-1:0] pin_analog,
  input wire logic [psl_pkg::ALL_PINS-1:0] impl_mask,
  output logic route_out
);
  typedef struct packed {
    logic q;
  } psl_mux_t;
  psl_mux_t m_r;
  psl_mux_t m_nxt;
  logic ok;

  // Select the pin; analog pins carry no digital value
  always_comb begin
    m_nxt = m_r;
    ok = (sel <= psl_pkg::MAX_VALID) &&
         impl_mask[sel]; // see RULE1
    m_nxt.q = ok && pin_in[sel] && !pin_analog[sel]; // see RULE22 RULE13
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      m_r <= '0;
    end else begin
      m_r <= m_nxt;
    end
  end

  assign route_out = m_r.q;

  a_invalid_low: assert property ( // see RULE1
    @(posedge clk) disable iff (!rst_b)
    (sel > psl_pkg::MAX_VALID) |=> !route_out)
    else $error("invalid input code routed a pin");
endmodule : psl_in_mux

// *** src/psl_pin_select.sv ***
// Purpose: Remappable pin select with lock, keys and shadow check
// Assumes: Register port strobes one cycle, read data next cycle
// Notes: Input fields pack two per register, as do output fields
//
// How it works
// RULE1: Codes for missing pins route no pin
// RULE2: Fields of missing output pins ignore writes
// RULE3: Locked mapping writes finish but change nothing
// RULE4: Lock is oscillator control bit six
// RULE5: Keys 46h, 57h, then lock write
// RULE6: Lock holds its value, never relocks itself
// RULE7: Shadow copies compared, mismatch raises reset request
// RULE8: One-way fuse freezes lock until reset
// RULE9: Fuse set allows one session only
// RULE10: Inputs reset all ones, outputs reset null
// RULE11: Lock is clear after reset
// RULE12: Mapping never enables peripherals or pin config
// RULE13: Analog pins carry no remapped signals
// RULE14: At most 44 pins, 12 input only
// RULE15: Small variant lacks listed pins
// RULE16: Software should relock after mapping writes
// RULE17: Software should park unused inputs and outputs
// RULE18: Output register holds two six-bit fields
// RULE19: Output code zero is null, undriven
// RULE20: Pins and functions may fan out freely
// RULE21: Key sequence needs consecutive writes
// RULE22: Invalid input codes give constant low
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module psl_pin_select #(
  parameter int NIN = 36,
  parameter bit SMALL_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [psl_pkg::ADDR_W-1:0] addr,
  input wire logic [psl_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [psl_pkg::DATA_W-1:0] rd_data,
  input wire logic [psl_pkg::DATA_W-1:0] config_word_two,
  input wire logic [psl_pkg::ALL_PINS-1:0] pin_in,
  input wire logic [psl_pkg::ALL_PINS-1:0] pin_analog,
  input wire logic [psl_pkg::NUM_CODES-1:0] periph_out,
  output logic [NIN-1:0] periph_in,
  output logic [psl_pkg::IO_PINS-1:0] pin_out,
  output logic [psl_pkg::IO_PINS-1:0] pin_oe,
  output logic mismatch_rst
);
  localparam int NREG_IN = (NIN + 1) / 2;
  localparam int NREG_OUT = psl_pkg::IO_PINS / 2;
  localparam int SW = psl_pkg::SEL_W;
  localparam int IOP = psl_pkg::IO_PINS;

  typedef struct packed {
    logic [NIN-1:0][SW-1:0] in_sel;
    logic [IOP-1:0][SW-1:0] out_sel;
    logic [NIN-1:0][SW-1:0] sh_in;
    logic [IOP-1:0][SW-1:0] sh_out;
    logic lock;
    logic lock_once;
    psl_pkg::psl_key_t key;
    logic [psl_pkg::DATA_W-1:0] rdata;
    logic mismatch;
    logic [IOP-1:0] pout;
    logic [IOP-1:0] poe;
  } psl_state_t;

  psl_state_t s_r;
  psl_state_t s_nxt;

  logic [63:0] impl;
  logic fuse;
  logic frozen;
  logic osc_hit;
  logic stat_hit;
  logic in_hit;
  logic out_hit;
  logic [7:0] in_idx;
  logic [7:0] out_idx;
  logic [7:0] low_byte;

  // Variant selects which pin codes exist
  assign impl = SMALL_VARIANT ? psl_pkg::IMPL_SMALL
                              : psl_pkg::IMPL_LARGE; // see RULE14 RULE15
  assign fuse = config_word_two[psl_pkg::FUSE_BIT]; // see RULE9
  // Once locked under the fuse, the keys are ignored until reset
  assign frozen = fuse && s_r.lock_once; // see RULE8
  assign low_byte = wr_data[7:0];

  // Address decode
  assign osc_hit = (addr == psl_pkg::OSC_IDX);
  assign stat_hit = (addr == psl_pkg::STAT_IDX);
  assign in_idx = addr - psl_pkg::IN_BASE;
  assign out_idx = addr - psl_pkg::OUT_BASE;
  assign in_hit = (addr >= psl_pkg::IN_BASE) &&
                  (in_idx < 8'(NREG_IN));
  assign out_hit = (addr >= psl_pkg::OUT_BASE) &&
                   (out_idx < 8'(NREG_OUT));

  // Next state: key sequence, mapping writes, reads, pin drive
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = '0;
    // Shadows only follow legal writes, so any drift shows here
    s_nxt.mismatch = (s_r.in_sel != s_r.sh_in) ||
                     (s_r.out_sel != s_r.sh_out); // see RULE7
    if (wr_en) begin
      // Any write outside the sequence aborts it
      s_nxt.key = psl_pkg::PSL_IDLE; // see RULE21
      if (osc_hit) begin
        unique case (s_r.key)
          psl_pkg::PSL_IDLE: begin
            if (low_byte == psl_pkg::KEY_FIRST && !frozen) begin
              s_nxt.key = psl_pkg::PSL_KEY1; // see RULE5
            end
          end
          psl_pkg::PSL_KEY1: begin
            if (low_byte == psl_pkg::KEY_SECOND) begin
              s_nxt.key = psl_pkg::PSL_KEY2; // see RULE5
            end else if (low_byte == psl_pkg::KEY_FIRST) begin
              s_nxt.key = psl_pkg::PSL_KEY1;
            end
          end
          psl_pkg::PSL_KEY2: begin
            // Lock changes only here and then simply stays
            s_nxt.lock = wr_data[psl_pkg::LOCK_BIT]; // see RULE4 RULE6
            if (wr_data[psl_pkg::LOCK_BIT]) begin
              s_nxt.lock_once = 1'b1; // see RULE8
            end
          end
          default: begin
            s_nxt.key = psl_pkg::PSL_IDLE;
          end
        endcase
      end
      // Locked writes are accepted silently and dropped
      for (int k = 0; k < NIN; k++) begin
        if (in_hit && !s_r.lock && in_idx == 8'(k / 2)) begin // see RULE3
          if (k % 2 == 1) begin
            s_nxt.in_sel[k] = wr_data[psl_pkg::HI_LSB +: SW];
          end else begin
            s_nxt.in_sel[k] = wr_data[SW-1:0];
          end
          s_nxt.sh_in[k] = s_nxt.in_sel[k];
        end
      end
      for (int j = 0; j < IOP; j++) begin
        if (out_hit && !s_r.lock && impl[j] &&
            out_idx == 8'(j / 2)) begin // see RULE2 RULE3 RULE18
          if (j % 2 == 1) begin
            s_nxt.out_sel[j] = wr_data[psl_pkg::HI_LSB +: SW];
          end else begin
            s_nxt.out_sel[j] = wr_data[SW-1:0];
          end
          s_nxt.sh_out[j] = s_nxt.out_sel[j];
        end
      end
    end
    // Reads land in the register, shown the next cycle
    if (rd_en) begin
      if (osc_hit) begin
        s_nxt.rdata[psl_pkg::LOCK_BIT] = s_r.lock;
      end else if (stat_hit) begin
        s_nxt.rdata[4:0] = {s_r.mismatch, fuse, s_r.lock_once,
                            s_r.key};
      end
      for (int k = 0; k < NIN; k++) begin
        if (in_hit && in_idx == 8'(k / 2)) begin
          if (k % 2 == 1) begin
            s_nxt.rdata[psl_pkg::HI_LSB +: SW] = s_r.in_sel[k];
          end else begin
            s_nxt.rdata[SW-1:0] = s_r.in_sel[k];
          end
        end
      end
      for (int j = 0; j < IOP; j++) begin
        if (out_hit && out_idx == 8'(j / 2)) begin
          if (j % 2 == 1) begin
            s_nxt.rdata[psl_pkg::HI_LSB +: SW] = s_r.out_sel[j];
          end else begin
            s_nxt.rdata[SW-1:0] = s_r.out_sel[j];
          end
        end
      end
    end
    // Pin drive: null code or analog pin leaves the pin alone
    for (int j = 0; j < IOP; j++) begin
      s_nxt.pout[j] = (s_r.out_sel[j] != psl_pkg::NULL_FN) &&
                      periph_out[s_r.out_sel[j]]; // see RULE20
      s_nxt.poe[j] = (s_r.out_sel[j] != psl_pkg::NULL_FN) &&
                     !pin_analog[j]; // see RULE13 RULE19
    end
  end

  // State register; lock and fields take their reset values
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.in_sel <= {NIN{psl_pkg::IN_RST}}; // see RULE10
      s_r.sh_in <= {NIN{psl_pkg::IN_RST}};
      s_r.out_sel <= {IOP{psl_pkg::OUT_RST}}; // see RULE10 RULE19
      s_r.sh_out <= {IOP{psl_pkg::OUT_RST}};
      s_r.lock <= 1'b0; // see RULE11
      s_r.key <= psl_pkg::PSL_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // One selector per peripheral input; fan-out of one pin is free
  genvar g;
  generate
    for (g = 0; g < NIN; g++) begin : g_in
      psl_in_mux u_mux (
        .clk(clk),
        .rst_b(rst_b),
        .sel(s_r.in_sel[g]),
        .pin_in(pin_in),
        .pin_analog(pin_analog),
        .impl_mask(impl[psl_pkg::ALL_PINS-1:0]),
        .route_out(periph_in[g])
      ); // see RULE1 RULE20 RULE22
    end
  endgenerate

  // Pin outputs only carry routing; peripheral enables stay outside
  assign rd_data = s_r.rdata;
  assign pin_out = s_r.pout; // see RULE12
  assign pin_oe = s_r.poe;
  assign mismatch_rst = s_r.mismatch;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence key1_wr;
    wr_en && osc_hit && low_byte == psl_pkg::KEY_FIRST && !frozen;
  endsequence
  sequence key2_wr;
    wr_en && osc_hit && low_byte == psl_pkg::KEY_SECOND;
  endsequence

  // Lock and key sequence checks
  a_lock_after_keys: assert property ( // see RULE5
    key1_wr ##1 key2_wr ##1 (wr_en && osc_hit) |=>
    s_r.lock == $past(wr_data[psl_pkg::LOCK_BIT]))
    else $error("lock did not follow key sequence");

  a_lock_needs_keys: assert property ( // see RULE5 RULE21
    $changed(s_r.lock) |-> $past(s_r.key) == psl_pkg::PSL_KEY2 &&
    $past(wr_en) && $past(osc_hit))
    else $error("lock changed without key sequence");

  a_lock_stays: assert property ( // see RULE6
    !wr_en |=> $stable(s_r.lock))
    else $error("lock changed on its own");

  a_locked_in_hold: assert property ( // see RULE3
    s_r.lock && wr_en && in_hit |=> $stable(s_r.in_sel))
    else $error("locked input write took effect");

  a_locked_out_hold: assert property ( // see RULE3
    s_r.lock && wr_en && out_hit |=> $stable(s_r.out_sel))
    else $error("locked output write took effect");

  a_fuse_freeze: assert property ( // see RULE8
    fuse && s_r.lock_once |=> s_r.lock && s_r.key ==
    psl_pkg::PSL_IDLE)
    else $error("one-way fuse let lock clear");

  a_abort_key: assert property ( // see RULE21
    s_r.key == psl_pkg::PSL_KEY1 && wr_en && !osc_hit |=>
    s_r.key == psl_pkg::PSL_IDLE)
    else $error("sequence survived a foreign write");

  // A foreign write after both keys must not move the lock
  a_abort_key2: assert property ( // see RULE21
    s_r.key == psl_pkg::PSL_KEY2 && wr_en && !osc_hit |=>
    s_r.key == psl_pkg::PSL_IDLE && $stable(s_r.lock))
    else $error("late foreign write changed the lock");

  // Pin routing checks, then shadow and lock readback checks
  a_null_undriven: assert property ( // see RULE19
    s_r.out_sel[0] == psl_pkg::NULL_FN |=> !pin_oe[0])
    else $error("null code drove a pin");

  a_null_no_out: assert property ( // see RULE19
    s_r.out_sel[0] == psl_pkg::NULL_FN |=> !pin_out[0])
    else $error("null code drove a value");

  a_missing_out: assert property ( // see RULE2
    !impl[5] |-> s_r.out_sel[5] == psl_pkg::OUT_RST)
    else $error("missing output field was written");

  a_analog_quiet: assert property ( // see RULE13
    pin_analog[1] |=> !pin_oe[1])
    else $error("analog pin driven by remap");

  // Two inputs on one code must see the same pin
  a_fanout_pin: assert property ( // see RULE20
    s_r.in_sel[2] == s_r.in_sel[4] |=> periph_in[2] == periph_in[4])
    else $error("fanned out pin reached inputs differently");

  // Shadows track every legal write, so this trips only on drift
  a_shadow_ok: assert property ( // see RULE7
    !mismatch_rst ##1 !mismatch_rst)
    else $error("shadow copy mismatch");

  a_read_next: assert property ( // see RULE4
    rd_en && osc_hit |=> rd_data[psl_pkg::LOCK_BIT] ==
    $past(s_r.lock))
    else $error("lock read back wrong");
endmodule : psl_pin_select

// *** verif/psl_periph_model.sv ***
// Purpose: Stand-in for pads and remappable peripherals
// Assumes: Bench sets levels just after a rising edge
// Notes: Pass-through; real pads add no state the block relies on
`timescale 1ns/1ns
module psl_periph_model (
  input wire logic [psl_pkg::ALL_PINS-1:0] pin_lvl,
  input wire logic [psl_pkg::NUM_CODES-1:0] fn_lvl,
  output logic [psl_pkg::ALL_PINS-1:0] pin_in,
  output logic [psl_pkg::NUM_CODES-1:0] periph_out
);
  // Pad levels and peripheral outputs as the bench commands them
  assign pin_in = pin_lvl;
  assign periph_out = fn_lvl;
endmodule : psl_periph_model

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench for the pin select block
// Assumes: Large variant, 36 peripheral inputs
// Notes: Bus tasks leave an idle cycle; key_seq runs back to back
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] rd_data;
  logic [15:0] config_word_two = 16'h0000;
  logic [43:0] pin_lvl = 44'h100_0000_0008;
  logic [43:0] pin_analog = 44'h000_0000_0000;
  logic [63:0] fn_lvl = 64'h0000_0010_0000_0008;
  logic [43:0] pin_in;
  logic [63:0] periph_out;
  logic [35:0] periph_in;
  logic [31:0] pin_out;
  logic [31:0] pin_oe;
  logic mismatch_rst;
  logic [15:0] rd_val;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  psl_periph_model i_model (.pin_lvl(pin_lvl), .fn_lvl(fn_lvl),
    .pin_in(pin_in), .periph_out(periph_out));

  psl_pin_select #(.NIN(36), .SMALL_VARIANT(1'b0)) i_dut (.clk(clk),
    .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .config_word_two(config_word_two),
    .pin_in(pin_in), .pin_analog(pin_analog), .periph_out(periph_out),
    .periph_in(periph_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .mismatch_rst(mismatch_rst));

  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input string name, input logic [63:0] exp,
                     input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    rd_val = rd_data;
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic do_reset(input logic [15:0] cfg);
    @(posedge clk);
    rst_b <= 1'b0;
    config_word_two <= cfg;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
  endtask : do_reset

  // Three consecutive writes, strobe held high between them
  task automatic key_seq(input logic lock_val);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= psl_pkg::OSC_IDX;
    wr_data <= {8'h00, psl_pkg::KEY_FIRST};
    @(posedge clk);
    wr_data <= {8'h00, psl_pkg::KEY_SECOND};
    @(posedge clk);
    wr_data <= {9'h000, lock_val, 6'h00};
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : key_seq

  task automatic t_reset();
    rd(psl_pkg::IN_BASE);
    chk("in_reg0", 64'h3f3f, 64'(rd_val));
    rd(psl_pkg::OUT_BASE);
    chk("out_reg0", 64'h0, 64'(rd_val));
    rd(psl_pkg::OSC_IDX);
    chk("lock", 64'h0, 64'(rd_val));
    rd(8'h3f);
    chk("unmapped", 64'h0, 64'(rd_val));
    chk("periph_in", 64'h0, 64'(periph_in));
    chk("pin_oe", 64'h0, 64'(pin_oe));
  endtask : t_reset

  // Invalid code 44, pin 63 tie-low and pin 40 feeding three inputs
  task automatic t_route();
    wr(psl_pkg::IN_BASE, 16'h2c03);
    wr(psl_pkg::IN_BASE + 8'h01, 16'h3f28);
    wr(psl_pkg::IN_BASE + 8'h02, 16'h2828);
    settle();
    chk("periph_in", 64'h35, 64'(periph_in[5:0]));
    @(posedge clk);
    pin_analog <= 44'h000_0000_0008;
    settle();
    chk("analog_in", 64'h34, 64'(periph_in[5:0]));
    wr(psl_pkg::OUT_BASE, 16'h0303);
    wr(psl_pkg::OUT_BASE + 8'h01, 16'h0024);
    settle();
    chk("pin_oe", 64'h7, 64'(pin_oe[3:0]));
    chk("pin_out", 64'h7, 64'(pin_out[3:0]));
    @(posedge clk);
    pin_analog <= 44'h000_0000_000a;
    settle();
    chk("analog_oe", 64'h5, 64'(pin_oe[3:0]));
    rd(psl_pkg::OUT_BASE);
    chk("out_reg0", 64'h0303, 64'(rd_val));
  endtask : t_route

  task automatic t_lock();
    key_seq(1'b1);
    rd(psl_pkg::OSC_IDX);
    chk("lock_set", 64'h40, 64'(rd_val));
    wr(psl_pkg::IN_BASE, 16'h0101);
    rd(psl_pkg::IN_BASE);
    chk("locked_wr", 64'h2c03, 64'(rd_val));
    // A foreign write between the keys must void the sequence
    wr(psl_pkg::OSC_IDX, 16'h0046);
    wr(psl_pkg::IN_BASE, 16'h0101);
    wr(psl_pkg::OSC_IDX, 16'h0057);
    wr(psl_pkg::OSC_IDX, 16'h0000);
    rd(psl_pkg::OSC_IDX);
    chk("abort", 64'h40, 64'(rd_val));
    // A foreign write after both keys voids the sequence too
    wr(psl_pkg::OSC_IDX, 16'h0046);
    wr(psl_pkg::OSC_IDX, 16'h0057);
    wr(psl_pkg::IN_BASE, 16'h0101);
    wr(psl_pkg::OSC_IDX, 16'h0000);
    rd(psl_pkg::OSC_IDX);
    chk("abort_late", 64'h40, 64'(rd_val));
    key_seq(1'b0);
    rd(psl_pkg::OSC_IDX);
    chk("unlock", 64'h0, 64'(rd_val));
    wr(psl_pkg::IN_BASE, 16'h0101);
    wr(psl_pkg::OUT_BASE, 16'h0000);
    rd(psl_pkg::IN_BASE);
    chk("session_in", 64'h0101, 64'(rd_val));
    rd(psl_pkg::OUT_BASE);
    chk("session_out", 64'h0, 64'(rd_val));
    key_seq(1'b1);
    rd(psl_pkg::OSC_IDX);
    chk("relock", 64'h40, 64'(rd_val));
  endtask : t_lock

  // Fuse set in config word two allows one session only
  task automatic t_fuse();
    do_reset(16'h0010);
    rd(psl_pkg::OSC_IDX);
    chk("lock_rst", 64'h0, 64'(rd_val));
    key_seq(1'b1);
    key_seq(1'b0);
    rd(psl_pkg::OSC_IDX);
    chk("fuse_lock", 64'h40, 64'(rd_val));
    wr(psl_pkg::IN_BASE, 16'h0101);
    rd(psl_pkg::IN_BASE);
    chk("fuse_wr", 64'h3f3f, 64'(rd_val));
    chk("mismatch", 64'h0, 64'(mismatch_rst));
  endtask : t_fuse

  initial begin
    do_reset(16'h0000);
    t_reset();
    t_route();
    t_lock();
    t_fuse();
    tally_and_finish();
  end
endmodule : tb_top
